// [design/stc_pkg.sv]
// package holding register map, field layout, reset values and encodings for the config bank
// Contract
// (R1) sync bytes two to four take part only as the sync length code allows
// (R2) sync length code: 00 eight, 01 sixteen, 10 twenty-four, 11 thirty-two bits
// (R3) address 22 holds the most significant sync byte, sent and matched first
// (R4) tx interpolation cutoff code is four bits, reset value 0111
// (R5) power code zero is full power, each step lowers output about 3 dB
// (R6) zero-IF bit forces first IF to zero and drops frequency deviation
// (R7) clock output pin driven only while its enable bit is set, set at reset
// (R8) divider zero gives crystal clock, else crystal over twice field, reset 01111
// (R9) Manchester coding applies only while its enable bit is set, clear at reset
// (R10) length field exact in fixed format, receive maximum only in variable format
// (R11) eight-bit node address, zero at reset, compared when filtering is on
// (R12) preamble of one to four bytes from two-bit code, reset code 10
// (R13) whitening applies only while its enable bit is set, clear at reset
// (R14) CRC generated and checked while CRC enable is set, set at reset
// (R15) address filter modes: off, node only, plus 0x00, plus 0x00 and 0xFF
// (R16) read-only CRC status bit, one for pass, writes ignored
// (R17) failed CRC clears FIFO unless the auto-clear control bit is one
// (R18) standby FIFO access is host write when bit is 0, read when 1
// (R19) format bit 0 selects fixed length, 1 variable length, reset 0
// (R20) host writes reserved fields only as zero
package stc_pkg;
    // ********************************************************************
    // register addresses
    // ********************************************************************
    localparam logic [4:0] ADDR_SYNC_FIRST = 5'h16;
    localparam logic [4:0] ADDR_SYNC_SECOND = 5'h17;
    localparam logic [4:0] ADDR_SYNC_THIRD = 5'h18;
    localparam logic [4:0] ADDR_SYNC_FOURTH = 5'h19;
    localparam logic [4:0] ADDR_TX_SET = 5'h1A;
    localparam logic [4:0] ADDR_CLK_SET = 5'h1B;
    localparam logic [4:0] ADDR_PKT_CODE = 5'h1C;
    localparam logic [4:0] ADDR_NODE = 5'h1D;
    localparam logic [4:0] ADDR_PKT_FMT = 5'h1E;
    localparam logic [4:0] ADDR_PKT_FIFO = 5'h1F;
    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [7:0] RST_SYNC = 8'h00;
    localparam logic [7:0] RST_TX_SET = 8'h72;
    localparam logic [7:0] RST_CLK_SET = 8'hBC;
    localparam logic [7:0] RST_PKT_CODE = 8'h00;
    localparam logic [7:0] RST_NODE = 8'h00;
    localparam logic [7:0] RST_PKT_FMT = 8'h48;
    localparam logic [7:0] RST_PKT_FIFO = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int TX_CUTOFF_LSB = 4;
    localparam int TX_POWER_LSB = 1;
    localparam int TX_ZERO_IF_BIT = 0;
    localparam int CLK_EN_BIT = 7;
    localparam int CLK_DIV_LSB = 2;
    localparam int MANCH_BIT = 7;
    localparam int FMT_VAR_BIT = 7;
    localparam int PREAMBLE_LSB = 5;
    localparam int WHITEN_BIT = 4;
    localparam int CRC_EN_BIT = 3;
    localparam int FILT_LSB = 1;
    localparam int CRC_STAT_BIT = 0;
    localparam int AUTOCLR_OFF_BIT = 7;
    localparam int STBY_READ_BIT = 6;
    // ********************************************************************
    // encodings
    // ********************************************************************
    localparam logic [1:0] SYNC_LEN_8 = 2'h0;
    localparam logic [1:0] SYNC_LEN_16 = 2'h1;
    localparam logic [1:0] SYNC_LEN_24 = 2'h2;
    localparam logic [1:0] SYNC_LEN_32 = 2'h3;
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [1:0] FILT_NODE = 2'h1;
    localparam logic [1:0] FILT_NODE_ZERO = 2'h2;
    localparam logic [1:0] FILT_NODE_BCAST = 2'h3;
    localparam logic [7:0] ADDR_ZERO = 8'h00;
    localparam logic [7:0] ADDR_BCAST = 8'hFF;
    localparam logic [4:0] DIV_UNDIVIDED = 5'h00;
endpackage

// [design/stc_clkout_div.sv]
// clock output divider: crystal rate or crystal over twice the divider field
`timescale 1ns/10ps
module stc_clkout_div
    import stc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [4:0] div,
    output logic clk_o
);
    logic [4:0] cnt_q;
    logic tog_q;
    logic neg_q;
    logic pos_q;

    // ********************************************************************
    // divided path
    // ********************************************************************
    // half period of div cycles, so a full period is 2*div cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            tog_q <= 1'b0;
        end else if (!enable || div == DIV_UNDIVIDED) begin
            cnt_q <= 5'h00;
            tog_q <= 1'b0;
        end else if (cnt_q >= div - 5'h01) begin // [R8]
            cnt_q <= 5'h00;
            tog_q <= ~tog_q;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // ********************************************************************
    // undivided path
    // ********************************************************************
    // one flop per edge; their xor follows the crystal without gating the clock
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 1'b0;
        end else begin
            pos_q <= ~neg_q;
        end
    end

    always_ff @(negedge mclk or negedge nrst) begin
        if (!nrst) begin
            neg_q <= 1'b0;
        end else begin
            neg_q <= pos_q;
        end
    end

    // output select; undivided path only while the field is zero
    assign clk_o = enable & ((div == DIV_UNDIVIDED) ? ~(pos_q ^ neg_q) : tog_q); // [R8]
endmodule

// [design/stc_cfg_bank.sv]
// sync, transmitter, clock output and packet handler configuration registers
`timescale 1ns/10ps
module stc_cfg_bank
    import stc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [4:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic [1:0] sync_len_code,
    output logic [31:0] sync_pattern,
    output logic [2:0] sync_bytes_m1,
    output logic [3:0] tx_interp_cutoff,
    output logic [2:0] tx_atten_steps,
    output logic tx_zero_if,
    output logic tx_dev_used,
    output logic clkout_o,
    output logic clkout_oe_n,
    output logic manch_en,
    output logic [6:0] tx_payload_len,
    output logic [6:0] rx_payload_len,
    output logic var_len_fmt,
    output logic [2:0] preamble_bytes_m1,
    output logic whiten_en,
    output logic crc_en,
    input wire logic rx_addr_valid,
    input wire logic [7:0] rx_addr,
    output logic rx_addr_accept,
    output logic rx_addr_reject,
    input wire logic crc_done,
    input wire logic crc_pass,
    output logic fifo_clear,
    input wire logic standby,
    output logic stby_fifo_wr,
    output logic stby_fifo_rd
);
    logic [7:0] sync_q [4];
    logic [7:0] tx_set_q;
    logic [7:0] clk_set_q;
    logic [7:0] pkt_code_q;
    logic [7:0] node_q;
    logic [7:0] pkt_fmt_q;
    logic [7:0] pkt_fifo_q;
    logic crc_stat_q;
    logic [7:0] rdata_d;
    logic wr_hit;
    logic clk_div_o;
    logic addr_match;

    assign wr_hit = cfg_sel & cfg_wr;

    // ********************************************************************
    // register writes
    // ********************************************************************
    // sync bytes, one flop group per byte, address 22 is the leading byte
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                sync_q[i] <= RST_SYNC;
            end else if (wr_hit && cfg_addr == ADDR_SYNC_FIRST + 5'(i)) begin // [R3]
                sync_q[i] <= cfg_wdata;
            end
        end
    end

    // control registers; reserved bits are kept as written, host keeps them zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_set_q <= RST_TX_SET; // [R4]
            clk_set_q <= RST_CLK_SET; // [R7] [R8]
            pkt_code_q <= RST_PKT_CODE; // [R9]
            node_q <= RST_NODE; // [R11]
            pkt_fmt_q <= RST_PKT_FMT; // [R12] [R13] [R14] [R19]
            pkt_fifo_q <= RST_PKT_FIFO; // [R17] [R18]
        end else if (wr_hit) begin
            unique case (cfg_addr)
                ADDR_TX_SET: tx_set_q <= cfg_wdata;
                ADDR_CLK_SET: clk_set_q <= cfg_wdata; // [R20]
                ADDR_PKT_CODE: pkt_code_q <= cfg_wdata;
                ADDR_NODE: node_q <= cfg_wdata;
                ADDR_PKT_FMT: pkt_fmt_q <= cfg_wdata;
                ADDR_PKT_FIFO: pkt_fifo_q <= cfg_wdata; // [R20]
                default: ;
            endcase
        end
    end

    // ********************************************************************
    // crc status
    // ********************************************************************
    // hardware-only bit; a host write to its position has no path here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            crc_stat_q <= 1'b0;
        end else if (crc_done) begin
            crc_stat_q <= crc_pass; // [R16]
        end
    end

    // failed check empties the FIFO unless the host turned auto-clear off
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fifo_clear <= 1'b0;
        end else begin
            fifo_clear <= crc_done & ~crc_pass & ~pkt_fifo_q[AUTOCLR_OFF_BIT]; // [R17]
        end
    end

    // ********************************************************************
    // read path
    // ********************************************************************
    always_comb begin
        rdata_d = RDATA_UNMAPPED;
        unique case (cfg_addr)
            ADDR_SYNC_FIRST: rdata_d = sync_q[0];
            ADDR_SYNC_SECOND: rdata_d = sync_q[1];
            ADDR_SYNC_THIRD: rdata_d = sync_q[2];
            ADDR_SYNC_FOURTH: rdata_d = sync_q[3];
            ADDR_TX_SET: rdata_d = tx_set_q;
            ADDR_CLK_SET: rdata_d = clk_set_q;
            ADDR_PKT_CODE: rdata_d = pkt_code_q;
            ADDR_NODE: rdata_d = node_q;
            ADDR_PKT_FMT: rdata_d = {pkt_fmt_q[7:1], crc_stat_q}; // [R16]
            ADDR_PKT_FIFO: rdata_d = pkt_fifo_q;
            default: rdata_d = RDATA_UNMAPPED;
        endcase
    end

    // data held until the next selected read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= RDATA_UNMAPPED;
        end else if (cfg_sel && !cfg_wr) begin
            cfg_rdata <= rdata_d;
        end
    end

    // ********************************************************************
    // sync word to the matcher
    // ********************************************************************
    // unused bytes forced to zero so a stale value never leaks into a match
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync_pattern <= 32'h0000_0000;
            sync_bytes_m1 <= 3'h3;
        end else begin
            sync_pattern[31:24] <= sync_q[0]; // [R3]
            sync_pattern[23:16] <= (sync_len_code != SYNC_LEN_8) ? sync_q[1] : 8'h00; // [R1]
            sync_pattern[15:8] <= sync_len_code[1] ? sync_q[2] : 8'h00; // [R1]
            sync_pattern[7:0] <= (sync_len_code == SYNC_LEN_32) ? sync_q[3] : 8'h00; // [R1]
            sync_bytes_m1 <= {1'b0, sync_len_code}; // [R2]
        end
    end

    // ********************************************************************
    // transmitter settings
    // ********************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_interp_cutoff <= RST_TX_SET[7:4];
            tx_atten_steps <= RST_TX_SET[3:1];
            tx_zero_if <= 1'b0;
            tx_dev_used <= 1'b1;
        end else begin
            tx_interp_cutoff <= tx_set_q[TX_CUTOFF_LSB +: 4]; // [R4]
            tx_atten_steps <= tx_set_q[TX_POWER_LSB +: 3]; // [R5]
            tx_zero_if <= tx_set_q[TX_ZERO_IF_BIT]; // [R6]
            tx_dev_used <= ~tx_set_q[TX_ZERO_IF_BIT]; // [R6]
        end
    end

    // ********************************************************************
    // clock output
    // ********************************************************************
    stc_clkout_div u_div (
        .mclk(mclk),
        .nrst(nrst),
        .enable(clk_set_q[CLK_EN_BIT]),
        .div(clk_set_q[CLK_DIV_LSB +: 5]),
        .clk_o(clk_div_o)
    );

    // pin level follows the divider; the undivided case cannot pass a flop
    assign clkout_o = clk_div_o; // [R8]

    // pin released while disabled; enable is active low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clkout_oe_n <= 1'b0;
        end else begin
            clkout_oe_n <= ~clk_set_q[CLK_EN_BIT]; // [R7]
        end
    end

    // ********************************************************************
    // packet handler options
    // ********************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            manch_en <= 1'b0;
            tx_payload_len <= 7'h00;
            rx_payload_len <= 7'h00;
            var_len_fmt <= 1'b0;
            preamble_bytes_m1 <= 3'h2;
            whiten_en <= 1'b0;
            crc_en <= 1'b1;
        end else begin
            manch_en <= pkt_code_q[MANCH_BIT]; // [R9]
            // variable format takes its length from the packet itself on transmit
            tx_payload_len <= pkt_fmt_q[FMT_VAR_BIT] ? 7'h00 : pkt_code_q[6:0]; // [R10]
            rx_payload_len <= pkt_code_q[6:0]; // [R10]
            var_len_fmt <= pkt_fmt_q[FMT_VAR_BIT]; // [R19]
            preamble_bytes_m1 <= {1'b0, pkt_fmt_q[PREAMBLE_LSB +: 2]}; // [R12]
            whiten_en <= pkt_fmt_q[WHITEN_BIT]; // [R13]
            crc_en <= pkt_fmt_q[CRC_EN_BIT]; // [R14]
        end
    end

    // ********************************************************************
    // address filter
    // ********************************************************************
    always_comb begin
        unique case (pkt_fmt_q[FILT_LSB +: 2])
            FILT_OFF: addr_match = 1'b1;
            FILT_NODE: addr_match = (rx_addr == node_q); // [R11]
            FILT_NODE_ZERO: addr_match = (rx_addr == node_q) || (rx_addr == ADDR_ZERO);
            FILT_NODE_BCAST: addr_match = (rx_addr == node_q) || (rx_addr == ADDR_ZERO)
                || (rx_addr == ADDR_BCAST);
        endcase
    end

    // one-cycle verdict one edge after the address is offered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_addr_accept <= 1'b0;
            rx_addr_reject <= 1'b0;
        end else begin
            rx_addr_accept <= rx_addr_valid & addr_match; // [R15]
            rx_addr_reject <= rx_addr_valid & ~addr_match; // [R15]
        end
    end

    // ********************************************************************
    // standby FIFO direction
    // ********************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stby_fifo_wr <= 1'b0;
            stby_fifo_rd <= 1'b0;
        end else begin
            stby_fifo_wr <= standby & ~pkt_fifo_q[STBY_READ_BIT]; // [R18]
            stby_fifo_rd <= standby & pkt_fifo_q[STBY_READ_BIT]; // [R18]
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_crc_fail_auto;
        crc_done && !crc_pass && !pkt_fifo_q[AUTOCLR_OFF_BIT];
    endsequence

    a_sync_short_mask: assert property ($past(sync_len_code) == SYNC_LEN_8
        |-> sync_pattern[23:0] == 24'h00_0000) else $error("unused sync bytes not zero"); // [R1]
    a_sync_len_code: assert property (sync_bytes_m1 == {1'b0, $past(sync_len_code)})
        else $error("sync length mismatch"); // [R2]
    a_sync_lead_byte: assert property (sync_pattern[31:24] == $past(sync_q[0]))
        else $error("leading sync byte wrong"); // [R3]
    a_zero_if_dev: assert property (tx_zero_if == $past(tx_set_q[TX_ZERO_IF_BIT]) // [R6]
        && tx_dev_used != tx_zero_if) else $error("zero-IF or deviation wrong");
    // pin level is gated by the same bit, so it is checked in the same cycle
    a_clkout_enable: assert property (!clk_set_q[CLK_EN_BIT] |-> !clkout_o ##1 clkout_oe_n)
        else $error("clock output active while disabled"); // [R7]
    a_crc_status_upd: assert property (crc_done |=> crc_stat_q == $past(crc_pass))
        else $error("crc status not updated"); // [R16]
    a_fifo_autoclr: assert property (s_crc_fail_auto |=> fifo_clear)
        else $error("fifo not cleared on crc fail"); // [R17]
    a_fifo_keep: assert property (crc_done && crc_pass |=> !fifo_clear)
        else $error("fifo cleared on pass"); // [R17]
    a_filter_bcast: assert property (rx_addr_valid && rx_addr == ADDR_BCAST
        && rx_addr != node_q && pkt_fmt_q[FILT_LSB +: 2] == FILT_NODE_ZERO
        |=> rx_addr_reject) else $error("broadcast accepted in mode 10"); // [R15]
    a_tx_len_var: assert property ($past(pkt_fmt_q[FMT_VAR_BIT]) |-> tx_payload_len == 7'h00)
        else $error("tx length used in variable format"); // [R10]
    a_stby_exclusive: assert property (!(stby_fifo_wr && stby_fifo_rd) // [R18]
        && (stby_fifo_wr || stby_fifo_rd) == $past(standby))
        else $error("standby fifo direction wrong");
endmodule

// [verification/stc_host_model.sv]
// host controller model driving the parallel configuration port
`timescale 1ns/10ps
module stc_host_model
    import stc_pkg::*;
(
    input wire logic mclk,
    output logic cfg_sel,
    output logic cfg_wr,
    output logic [4:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata
);
    // idle port at time zero
    initial begin
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 5'h00;
        cfg_wdata = 8'h00;
    end

    // one access, launched after a falling edge and held over the taking edge
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk);
        cfg_sel <= 1'b1;
        cfg_wr <= w;
        cfg_addr <= a;
        cfg_wdata <= d & ((a == ADDR_CLK_SET) ? 8'hFC
            : (a == ADDR_PKT_FIFO) ? 8'hC0 : 8'hFF);
        @(posedge mclk);
        @(negedge mclk);
        // released lines show the inverse so a stale value cannot pass for a live one
        cfg_sel <= 1'b0;
        cfg_wr <= ~w;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask

    // read data stands until the next read, so sample a full cycle later
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        access(1'b0, a, 8'hA5);
        @(negedge mclk);
        d = cfg_rdata;
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the sync, transmitter, clock output and packet option bank
`timescale 1ns/10ps
module testbench;
    import stc_pkg::*;
    logic mclk, nrst, cfg_sel, cfg_wr, tx_zero_if, tx_dev_used, clkout_o, clkout_oe_n;
    logic manch_en, var_len_fmt, whiten_en, crc_en, rx_addr_valid, rx_addr_accept;
    logic rx_addr_reject, crc_done, crc_pass, fifo_clear, standby, stby_fifo_wr, stby_fifo_rd;
    logic [4:0] cfg_addr, ra;
    logic [7:0] cfg_wdata, cfg_rdata, rx_addr, v;
    logic [1:0] sync_len_code;
    logic [31:0] sync_pattern;
    logic [2:0] sync_bytes_m1, tx_atten_steps, preamble_bytes_m1;
    logic [3:0] tx_interp_cutoff;
    logic [6:0] tx_payload_len, rx_payload_len;
    logic [8:0] txo;
    logic [14:0] pko;
    logic [5:0] fmo;
    logic [7:0] m [22:31];
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int edges = 0;

    stc_cfg_bank stc_cfg_bank_i (.mclk, .nrst, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata,
        .cfg_rdata, .sync_len_code, .sync_pattern, .sync_bytes_m1, .tx_interp_cutoff,
        .tx_atten_steps, .tx_zero_if, .tx_dev_used, .clkout_o, .clkout_oe_n, .manch_en,
        .tx_payload_len, .rx_payload_len, .var_len_fmt, .preamble_bytes_m1, .whiten_en,
        .crc_en, .rx_addr_valid, .rx_addr, .rx_addr_accept, .rx_addr_reject, .crc_done,
        .crc_pass, .fifo_clear, .standby, .stby_fifo_wr, .stby_fifo_rd);
    stc_host_model stc_host_model_i (.mclk, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_wdata,
        .cfg_rdata);

    // grouped outputs keep the compare lines short
    assign txo = {tx_interp_cutoff, tx_atten_steps, tx_zero_if, tx_dev_used};
    assign pko = {manch_en, rx_payload_len, tx_payload_len};
    assign fmo = {var_len_fmt, preamble_bytes_m1, whiten_en, crc_en};

    // clock source
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // rising edges of the clock output pin, for the rate measurement
    always @(posedge clkout_o) edges++;

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    // ****************************************************************
    // checking helpers and reference model
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // write through the host and mirror it; the status bit is not writable
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] k;
        k = (a == ADDR_CLK_SET) ? 8'hFC : (a == ADDR_PKT_FIFO) ? 8'hC0 : 8'hFF;
        stc_host_model_i.wr(a, d);
        if (a >= ADDR_SYNC_FIRST) begin
            m[a] = (a == ADDR_PKT_FMT) ? {d[7:1], m[a][0]} : d & k;
        end
    endtask

    task automatic rchk(input logic [4:0] a);
        stc_host_model_i.rd(a, v);
        chk(v, (a >= ADDR_SYNC_FIRST) ? m[a] : 8'h00, "register read");
    endtask

    task automatic chk_out();
        logic [31:0] sp;
        sp = {m[22], m[23], m[24], m[25]} & ~(32'hFFFFFFFF >> (8 * (sync_len_code + 1)));
        chk(sync_pattern, sp, "sync pattern");
        chk(sync_bytes_m1, sync_len_code, "sync size");
        chk(txo, {m[26], ~m[26][0]}, "tx settings");
        chk(clkout_oe_n, !m[27][7], "clock output enable");
        chk(pko, {m[28], m[30][7] ? 7'h00 : m[28][6:0]}, "coding and length");
        chk(fmo, {m[30][7], 1'b0, m[30][6:3]}, "packet options");
    endtask

    task automatic filt(input logic [7:0] a);
        logic acc;
        acc = (m[30][2:1] == 2'h0) || (a == m[29]) || (m[30][2] && a == 8'h00)
            || (m[30][2:1] == 2'h3 && a == 8'hFF);
        @(negedge mclk);
        rx_addr_valid = 1'b1;
        rx_addr = a;
        @(negedge mclk);
        rx_addr_valid = 1'b0;
        rx_addr = ~a;
        chk({rx_addr_accept, rx_addr_reject}, {acc, ~acc}, "filter");
        @(negedge mclk);
        chk({rx_addr_accept, rx_addr_reject}, 2'h0, "filter pulse");
    endtask

    task automatic crc(input logic p);
        @(negedge mclk);
        crc_done = 1'b1;
        crc_pass = p;
        @(negedge mclk);
        crc_done = 1'b0;
        crc_pass = 1'($urandom);
        chk(fifo_clear, !p && !m[31][7], "fifo clear");
        m[30][0] = p;
        @(negedge mclk);
        chk(fifo_clear, 1'b0, "clear pulse");
        rchk(ADDR_PKT_FMT);
    endtask

    // edge count over 120 cycles; one edge of slack for the window phase
    task automatic clk_meas(input logic [7:0] s);
        int e;
        wreg(ADDR_CLK_SET, s);
        repeat (6) @(negedge mclk);
        edges = 0;
        repeat (120) @(negedge mclk);
        e = !s[7] ? 0 : (s[6:2] == 5'h00) ? 120 : 120 / (2 * s[6:2]);
        chk(e == 0 ? edges == 0 : edges >= e - 1 && edges <= e + 1, 1'b1,
            "clock rate");
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [7:0] cs [6];
        cs = '{8'h80, 8'h84, 8'h88, 8'hBC, 8'hFC, 8'h3C};
        nrst = 1'b0;
        sync_len_code = 2'h3;
        rx_addr_valid = 1'b0;
        rx_addr = 8'h00;
        crc_done = 1'b0;
        crc_pass = 1'b0;
        standby = 1'b0;
        void'($urandom(32'hde671f90));
        for (int a = 22; a < 32; a++) m[a] = 8'h00;
        m[26] = {4'h7, 3'h1, 1'b0};
        m[27] = {1'b1, 5'h0F, 2'h0};
        m[30] = {1'b0, 2'h2, 1'b0, 1'b1, 2'h0, 1'b0};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        nrst = 1'b1;
        for (int a = 16; a < 32; a++) rchk(a[4:0]);
        chk_out();
        wreg(5'h10, 8'h5A);
        rchk(5'h10);
        // random traffic across the whole bank and every sync length
        for (int i = 0; i < 40; i++) begin
            ra = ADDR_SYNC_FIRST + 5'($urandom % 10);
            wreg(ra, 8'($urandom));
            sync_len_code = i[1:0];
            repeat (2) @(negedge mclk);
            chk_out();
            rchk(ra);
        end
        wreg(ADDR_NODE, 8'h3C);
        for (int md = 0; md < 4; md++) begin
            wreg(ADDR_PKT_FMT, {m[30][7:3], md[1:0], 1'b0});
            filt(8'h3C);
            filt(8'h00);
            filt(8'hFF);
            filt(8'($urandom));
        end
        for (int c = 0; c < 4; c++) begin
            wreg(ADDR_PKT_FIFO, {c[1], 7'h00});
            crc(c[0]);
            wreg(ADDR_PKT_FMT, {m[30][7:1], ~m[30][0]});
            rchk(ADDR_PKT_FMT);
        end
        for (int b = 0; b < 2; b++) begin
            wreg(ADDR_PKT_FIFO, {m[31][7], b[0], 6'h00});
            for (int s = 0; s < 2; s++) begin
                @(negedge mclk);
                standby = s[0];
                repeat (2) @(negedge mclk);
                chk({stby_fifo_wr, stby_fifo_rd}, {s[0] & ~b[0], s[0] & b[0]}, "standby");
            end
        end
        foreach (cs[j]) clk_meas(cs[j]);
        end_of_test();
    end
endmodule
